// [uer_regs.sv]
/*
  Enhanced register set of one UART channel: second transmit-off character,
  revision and identification readback, trigger level write, alternating FIFO
  fill readback, feature control, advanced special and sample clock registers,
  plus the auto-RTS decision with hysteresis.
  Assumes the line control, divisor latches and enhanced feature register live
  elsewhere in the channel and arrive here as same-clock inputs.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module uer_regs #(
  parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE   = 8'h5a  // Arbitrary value
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [7:0]            line_control_reg_i,
  input  wire logic [7:0]            divisor_latch_low_i,
  input  wire logic [7:0]            divisor_latch_high_i,
  input  wire logic [7:0]            enhanced_feature_reg_i,
  input  wire logic [6:0]            rx_fill_i,
  input  wire logic [6:0]            tx_fill_i,
  input  wire logic [6:0]            table_rx_level_i,
  input  wire logic                  auto_rts_en_i,
  output logic      [7:0]            second_xoff_character_o,
  output logic      [6:0]            receive_trigger_level_o,
  output logic      [6:0]            transmit_trigger_level_o,
  output logic      [1:0]            trigger_table_o,
  output logic      [5:0]            hysteresis_o,
  output uer_pkg::uer_asr_t          advanced_special_o,
  output uer_pkg::uer_snr_t          sample_clock_baud_o,
  output logic                       rts_ready_o
);

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  // Hysteresis in characters for a feature control code
  function automatic logic [5:0] hyst_chars(input logic [3:0] code);
    logic [5:0] h;
    h = 6'h00;
    case (code)
      4'h0:    h = 6'h00;
      4'h1:    h = 6'h04;
      4'h2:    h = 6'h06;
      4'h3:    h = 6'h08;
      4'h4:    h = 6'h08;
      4'h5:    h = 6'h10;
      4'h6:    h = 6'h18;
      4'h7:    h = 6'h20;
      4'h8:    h = 6'h28;
      4'h9:    h = 6'h2c;
      4'ha:    h = 6'h30;
      4'hb:    h = 6'h34;
      4'hc:    h = 6'h0c;
      4'hd:    h = 6'h14;
      4'he:    h = 6'h1c;
      4'hf:    h = 6'h24;
      default: h = 6'h00;
    endcase
    return h;
  endfunction

  // Whether an index answers in the current page for this direction
  function automatic logic reg_hit(input logic [2:0]         idx,
                                   input logic               wr,
                                   input uer_pkg::uer_page_t pg,
                                   input logic [7:0]         dll,
                                   input logic [7:0]         divisor_latch_high,
                                   input logic               enh,
                                   input logic               snr_en);
    logic h;
    h = 1'b0;
    case (pg)
      uer_pkg::PG_ENH: begin
        h = (idx == uer_pkg::IDX_TRG) || (idx == uer_pkg::IDX_FEATURE_CONTROL)
            || (idx == uer_pkg::IDX_SECOND_XOFF_CHARACTER);
      end
      uer_pkg::PG_DIV: begin
        if (idx == uer_pkg::IDX_REV)
          h = !wr && (dll == uer_pkg::DL_ZERO);
        else if (idx == uer_pkg::IDX_ID)
          h = !wr && (dll == uer_pkg::DL_ZERO) && (divisor_latch_high == uer_pkg::DL_ZERO);
        else if (idx == uer_pkg::IDX_AFR)
          h = !enh;
        else if (idx == uer_pkg::IDX_ASR)
          h = enh;
        else if (idx == uer_pkg::IDX_SNR)
          h = snr_en;
        else
          h = 1'b0;
      end
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  // ------------------------------------------------
  // State
  // ------------------------------------------------
  logic [7:0]          second_xoff_character_r;
  logic [6:0]          rx_trg_r;
  logic [6:0]          tx_trg_r;
  uer_pkg::uer_feature_control_t  feature_control_r;
  logic                afr_r;
  uer_pkg::uer_asr_t   asr_r;
  uer_pkg::uer_snr_t   snr_r;
  logic                fc_sel_r;
  logic                rts_r;
  logic [7:0]          rdata_r;
  logic                err_r;

  // ------------------------------------------------
  // Decode
  // ------------------------------------------------
  uer_pkg::uer_page_t  page;
  logic [2:0]          idx;
  logic                in_map;
  logic                hit;
  logic                acc;
  logic                wr_go;
  logic                rd_go;
  logic [7:0]          wbyte;
  logic [7:0]          rd_nxt;

  always_comb begin
    if (line_control_reg_i == uer_pkg::LCR_ENH)
      page = uer_pkg::PG_ENH;
    else if (line_control_reg_i[uer_pkg::DIV_BIT])
      page = uer_pkg::PG_DIV;
    else
      page = uer_pkg::PG_NONE;
  end

  assign idx    = paddr_i[uer_pkg::IDX_LSB +: 3];
  assign in_map = (paddr_i[1:0] == 2'h0)
                  && (paddr_i[uer_pkg::ADDR_W-1:5] == 3'h0);
  assign hit    = in_map && reg_hit(idx, pwrite_i, page, divisor_latch_low_i,
                                    divisor_latch_high_i,
                                    enhanced_feature_reg_i[uer_pkg::EFR_ENH_BIT],
                                    asr_r.snr_en);
  assign acc    = psel_i && penable_i;
  // Only the low byte lane carries register data
  assign wr_go  = acc && pwrite_i && hit && pstrb_i[0];
  assign rd_go  = acc && !pwrite_i && hit;
  assign wbyte  = pwdata_i[7:0];

  // ------------------------------------------------
  // Read data mux, sampled in the setup cycle
  // ------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    if (page == uer_pkg::PG_ENH) begin
      case (idx)
        uer_pkg::IDX_FC:    rd_nxt = {fc_sel_r, fc_sel_r ? tx_fill_i : rx_fill_i};
        uer_pkg::IDX_FEATURE_CONTROL:  rd_nxt = {2'h0, feature_control_r.table_sel, feature_control_r.hyst_sel};
        uer_pkg::IDX_SECOND_XOFF_CHARACTER: rd_nxt = second_xoff_character_r;
        default:            rd_nxt = 8'h00;
      endcase
    end else begin
      case (idx)
        uer_pkg::IDX_REV:   rd_nxt = REVISION_CODE;
        uer_pkg::IDX_ID:    rd_nxt = DEVICE_CODE;
        uer_pkg::IDX_AFR:   rd_nxt = {6'h00, afr_r, 1'b0};
        uer_pkg::IDX_ASR:   rd_nxt = asr_r;
        uer_pkg::IDX_SNR:   rd_nxt = snr_r;
        default:            rd_nxt = 8'h00;
      endcase
    end
  end

  // Latching the answer in setup keeps prdata on a flop and still zero-wait
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 8'h00;
      err_r   <= 1'b0;
    end else if (psel_i && !penable_i) begin
      rdata_r <= (hit && !pwrite_i) ? rd_nxt : 8'h00;
      err_r   <= !hit;
    end
  end

  assign pready_o  = acc;
  assign prdata_o  = {24'h000000, rdata_r};
  assign pslverr_o = acc && err_r;

  // ------------------------------------------------
  // Enhanced page registers
  // ------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      second_xoff_character_r <= uer_pkg::RST_SECOND_XOFF_CHARACTER;
    end else if (wr_go && page == uer_pkg::PG_ENH && idx == uer_pkg::IDX_SECOND_XOFF_CHARACTER) begin
      second_xoff_character_r <= wbyte;
    end
  end

  // Out-of-range levels are dropped so the table never sees more than the FIFO holds
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_trg_r <= uer_pkg::RST_TRG;
      tx_trg_r <= uer_pkg::RST_TRG;
    end else if (wr_go && page == uer_pkg::PG_ENH && idx == uer_pkg::IDX_TRG
                 && wbyte[6:0] <= uer_pkg::TRG_MAX) begin
      if (wbyte[uer_pkg::TRG_SEL_BIT])
        tx_trg_r <= wbyte[6:0];
      else
        rx_trg_r <= wbyte[6:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fc_sel_r <= 1'b0;
    end else if (rd_go && page == uer_pkg::PG_ENH && idx == uer_pkg::IDX_FC) begin
      fc_sel_r <= !fc_sel_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      feature_control_r <= uer_pkg::RST_FEATURE_CONTROL;
    end else if (wr_go && page == uer_pkg::PG_ENH && idx == uer_pkg::IDX_FEATURE_CONTROL) begin
      feature_control_r.table_sel <= wbyte[5:4];
      feature_control_r.hyst_sel  <= wbyte[3:0];
    end
  end

  // ------------------------------------------------
  // Divisor page registers
  // ------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      afr_r <= uer_pkg::RST_AFR;
    end else if (wr_go && page == uer_pkg::PG_DIV && idx == uer_pkg::IDX_AFR) begin
      afr_r <= wbyte[uer_pkg::AFR_USED_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      asr_r <= uer_pkg::RST_ASR;
    end else if (wr_go && page == uer_pkg::PG_DIV && idx == uer_pkg::IDX_ASR) begin
      asr_r <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      snr_r <= uer_pkg::RST_SNR;
    end else if (wr_go && page == uer_pkg::PG_DIV && idx == uer_pkg::IDX_SNR) begin
      snr_r <= wbyte;
    end
  end

  // ------------------------------------------------
  // Control outputs
  // ------------------------------------------------
  assign second_xoff_character_o  = second_xoff_character_r;
  assign receive_trigger_level_o  = rx_trg_r;
  assign transmit_trigger_level_o = tx_trg_r;
  assign trigger_table_o          = feature_control_r.table_sel;
  assign hysteresis_o             = hyst_chars(feature_control_r.hyst_sel);
  // Bits 7..0 drive RS-485 access, TX/RX disable, IrDA format, polarity,
  // sample clock enable, IrDA mode and FIFO ready block in the channel
  assign advanced_special_o       = asr_r;
  // Baud generator relies on software keeping the difference legal
  assign sample_clock_baud_o      = snr_r;

  // ------------------------------------------------
  // Auto RTS
  // ------------------------------------------------
  logic       tbl_d;
  logic [7:0] eff_trig;
  logic [7:0] eff_hyst;
  logic [7:0] hi_mark;
  logic [7:0] lo_mark;

  assign tbl_d    = (feature_control_r.table_sel == uer_pkg::TABLE_D);
  assign eff_trig = {1'b0, tbl_d ? rx_trg_r : table_rx_level_i};
  assign eff_hyst = tbl_d ? {2'h0, hyst_chars(feature_control_r.hyst_sel)} : 8'h00;
  assign hi_mark  = eff_trig + eff_hyst;
  assign lo_mark  = (eff_trig > eff_hyst) ? eff_trig - eff_hyst : 8'h00;

  // Between the marks RTS holds, which is what stops it chattering
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rts_r <= 1'b1;
    end else if (!auto_rts_en_i) begin
      rts_r <= 1'b1;
    end else if ({1'b0, rx_fill_i} >= hi_mark) begin
      rts_r <= 1'b0;
    end else if (eff_hyst == 8'h00 || {1'b0, rx_fill_i} <= lo_mark) begin
      rts_r <= 1'b1;
    end
  end

  assign rts_ready_o = rts_r;

  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr(logic [2:0] i, uer_pkg::uer_page_t p);
    acc && pwrite_i && pstrb_i[0] && in_map && idx == i && page == p;
  endsequence

  sequence s_setup_rd(logic [2:0] i);
    psel_i && !penable_i && !pwrite_i && in_map && idx == i;
  endsequence

  second_xoff_character_write_a: assert property (
    s_wr(uer_pkg::IDX_SECOND_XOFF_CHARACTER, uer_pkg::PG_ENH) |=> second_xoff_character_o == $past(pwdata_i[7:0]))
    else $error("second_xoff_character not loaded");

  rev_read_a: assert property (
    s_setup_rd(uer_pkg::IDX_REV) && page == uer_pkg::PG_DIV && divisor_latch_low_i == 8'h00
    |=> prdata_o[7:0] == REVISION_CODE && !pslverr_o)
    else $error("revision read wrong");

  id_read_a: assert property (
    s_setup_rd(uer_pkg::IDX_ID) && page == uer_pkg::PG_DIV && divisor_latch_low_i == 8'h00
    && divisor_latch_high_i == 8'h00 |=> prdata_o[7:0] == DEVICE_CODE)
    else $error("identification read wrong");

  trg_select_a: assert property (
    s_wr(uer_pkg::IDX_TRG, uer_pkg::PG_ENH) && pwdata_i[7] && pwdata_i[6:0] <= 7'h40
    |=> tx_trg_r == $past(pwdata_i[6:0]) && $stable(rx_trg_r))
    else $error("tx trigger not selected");

  trg_range_a: assert property (
    s_wr(uer_pkg::IDX_TRG, uer_pkg::PG_ENH) && pwdata_i[6:0] > 7'h40
    |=> $stable(rx_trg_r) && $stable(tx_trg_r))
    else $error("trigger over range taken");

  fc_alternate_a: assert property (
    s_setup_rd(uer_pkg::IDX_FC) && page == uer_pkg::PG_ENH ##1 acc
    |=> fc_sel_r != $past(fc_sel_r, 2))
    else $error("fill counter source did not swap");

  asr_hidden_a: assert property (
    s_wr(uer_pkg::IDX_ASR, uer_pkg::PG_DIV) && !enhanced_feature_reg_i[4] |=> $stable(asr_r))
    else $error("advanced register written while hidden");

  tx_disable_a: assert property (
    s_wr(uer_pkg::IDX_ASR, uer_pkg::PG_DIV) && enhanced_feature_reg_i[4]
    |=> advanced_special_o.tx_dis == $past(pwdata_i[6]))
    else $error("transmitter disable not applied");

  snr_gate_a: assert property (
    s_wr(uer_pkg::IDX_SNR, uer_pkg::PG_DIV) && !asr_r.snr_en |=> $stable(snr_r))
    else $error("sample clock written while disabled");

  rts_release_a: assert property (
    auto_rts_en_i && {1'b0, rx_fill_i} >= hi_mark |=> !rts_ready_o)
    else $error("rts not released at high mark");

  hyst_table_a: assert property (
    !tbl_d |-> eff_hyst == 8'h00 && eff_trig == {1'b0, table_rx_level_i})
    else $error("hysteresis applied outside table D");

endmodule

// [uer_pkg.sv]
/*
  Package for the enhanced register set of one UART channel.
  It holds the register indices, reset values, page codes and field layouts.
  It assumes that the host reaches the registers over APB with one word per index.
*/
package uer_pkg;

  // ------------------------------------------------
  // Register indices (byte address = index * 4)
  // ------------------------------------------------
  localparam logic [2:0] IDX_REV   = 3'h0;
  localparam logic [2:0] IDX_ID    = 3'h1;
  localparam logic [2:0] IDX_AFR   = 3'h2;
  localparam logic [2:0] IDX_ASR   = 3'h4;
  localparam logic [2:0] IDX_SNR   = 3'h5;
  localparam logic [2:0] IDX_SECOND_XOFF_CHARACTER = 3'h7;
  localparam logic [2:0] IDX_TRG   = 3'h0;
  localparam logic [2:0] IDX_FC    = 3'h0;
  localparam logic [2:0] IDX_FEATURE_CONTROL  = 3'h1;
  localparam int         ADDR_W    = 8;
  localparam int         IDX_LSB   = 2;

  // ------------------------------------------------
  // Values and reset values
  // ------------------------------------------------
  localparam logic [7:0] LCR_ENH      = 8'hbf;
  localparam logic [7:0] DL_ZERO      = 8'h00;
  localparam logic [6:0] TRG_MAX      = 7'h40;
  localparam int         TRG_SEL_BIT  = 7;
  localparam int         EFR_ENH_BIT  = 4;
  localparam int         DIV_BIT      = 7;
  localparam int         AFR_USED_BIT = 1;
  localparam logic [7:0] RST_SECOND_XOFF_CHARACTER    = 8'h00;
  localparam logic [7:0] RST_ASR      = 8'h00;
  localparam logic [7:0] RST_SNR      = 8'h00;
  localparam logic [7:0] RST_FEATURE_CONTROL     = 8'h00;
  localparam logic       RST_AFR      = 1'b0;
  localparam logic [6:0] RST_TRG      = 7'h00;
  localparam logic [1:0] TABLE_D      = 2'h3;

  typedef enum logic [1:0] {
    PG_NONE = 2'b00,
    PG_ENH  = 2'b01,
    PG_DIV  = 2'b10
  } uer_page_t;

  typedef struct packed {
    logic rs485_en;
    logic tx_dis;
    logic rx_dis;
    logic irda_fast;
    logic irda_rx_inv;
    logic snr_en;
    logic irda_en;
    logic fifo_rdy_dis;
  } uer_asr_t;

  typedef struct packed {
    logic [3:0] sample_clock_value;
    logic [3:0] baud_n_term;
  } uer_snr_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] table_sel;
    logic [3:0] hyst_sel;
  } uer_feature_control_t;

endpackage

// [uer_host_model.sv]
/*
  Host processor model on the APB register bus of the enhanced register set.
  Assumes one clock shared with the block and a caller that runs one transfer at a time.
*/
`timescale 1ns/1ps
module uer_host_model (
  input  wire logic        sys_clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    pstrb_o = 4'h0;
  end

  // ----------------------------------------
  // One transfer, bounded wait for pready
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] d, input logic [3:0] strb,
                      output logic [7:0] rdata, output logic err, output logic ok);
    ok = 1'b0;
    rdata = 8'h00;
    err = 1'b0;
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= {3'h0, idx, 2'h0};
    pwdata_o <= {24'h00_0000, d};
    pstrb_o <= strb;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk_i);
      if (pready_i === 1'b1) begin
        ok = 1'b1;
        rdata = prdata_i[7:0];
        err = pslverr_i;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released address and data lines flip so a stale value never looks live
    paddr_o <= ~paddr_o;
    pwdata_o <= ~pwdata_o;
  endtask
endmodule

// [uer_regs_test.sv]
/*
  Self-checking bench for the enhanced register set: paging, register access, trigger,
  fill counter, feature control decode and auto RTS hysteresis.
  Assumes the host model drives APB and the bench drives the page inputs and FIFO counts.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uer_regs_test;
  localparam logic [7:0] REV_CODE = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEV_CODE = 8'ha7; // Arbitrary value
  logic              sys_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              psel, penable, pwrite, pready, pslverr, rts_en = 1'b0, rts;
  logic [7:0]        paddr, line_control_reg = 8'h00, dll = 8'h00, divisor_latch_high = 8'h00, enhanced_feature_reg = 8'h00, second_xoff_character, d;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb, c, sc, np;
  logic [6:0]        rx_fill = 7'h00, tx_fill = 7'h00, tbl_lvl = 7'h00, rxt, txt, v, t;
  logic [1:0]        tbl;
  logic [5:0]        hyst, h;
  uer_pkg::uer_asr_t advanced_special;
  uer_pkg::uer_snr_t sample_clock_baud;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                i;

  always #2 sys_clk_i = ~sys_clk_i;

  uer_host_model u_host (.sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  uer_regs #(.REVISION_CODE(REV_CODE), .DEVICE_CODE(DEV_CODE)) u_dut (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .line_control_reg_i(line_control_reg), .divisor_latch_low_i(dll), .divisor_latch_high_i(divisor_latch_high),
    .enhanced_feature_reg_i(enhanced_feature_reg), .rx_fill_i(rx_fill), .tx_fill_i(tx_fill), .table_rx_level_i(tbl_lvl),
    .auto_rts_en_i(rts_en), .second_xoff_character_o(second_xoff_character), .receive_trigger_level_o(rxt),
    .transmit_trigger_level_o(txt), .trigger_table_o(tbl), .hysteresis_o(hyst),
    .advanced_special_o(advanced_special), .sample_clock_baud_o(sample_clock_baud), .rts_ready_o(rts));

  // ----------------------------------------
  // Expectations and bus helpers
  // ----------------------------------------
  function automatic logic [5:0] hyst_of(input logic [3:0] code);
    logic [5:0] tab [16];
    tab = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
            6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
    return tab[code];
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [2:0] idx, input logic [7:0] dv, input logic [3:0] s,
                     input logic [7:0] xd, input logic xe);
    logic [7:0] rd;
    logic er;
    logic ok;
    u_host.xfer(wr, idx, dv, s, rd, er, ok);
    if (!ok) begin
      error_cnt++;
      close_out();
    end else begin
      `CHK(er, xe)
      if (!wr) `CHK(rd, xd)
    end
  endtask

  task automatic wrt(input logic [2:0] idx, input logic [7:0] dv, input logic xe);
    acc(1'b1, idx, dv, 4'h1, 8'h00, xe);
  endtask

  task automatic rdc(input logic [2:0] idx, input logic [7:0] xd, input logic xe);
    acc(1'b0, idx, 8'h00, 4'h0, xd, xe);
  endtask

  task automatic pg(input logic [7:0] l, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ef);
    @(posedge sys_clk_i);
    line_control_reg <= l;
    dll <= lo;
    divisor_latch_high <= hi;
    enhanced_feature_reg <= ef;
  endtask

  // One cycle of decision latency, checked a cycle later
  task automatic fill(input logic [6:0] f, input logic e);
    @(posedge sys_clk_i);
    rx_fill <= f;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK(rts, e)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(12336));
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    pg(8'h80, 8'h00, 8'h00, 8'h10);
    rdc(uer_pkg::IDX_ASR, uer_pkg::RST_ASR, 1'b0);
    rdc(uer_pkg::IDX_SNR, 8'h00, 1'b1);
    rdc(uer_pkg::IDX_REV, REV_CODE, 1'b0);
    rdc(uer_pkg::IDX_ID, DEV_CODE, 1'b0);
    rdc(uer_pkg::IDX_AFR, 8'h00, 1'b1);
    rdc(3'h3, 8'h00, 1'b1);
    rdc(uer_pkg::IDX_SECOND_XOFF_CHARACTER, 8'h00, 1'b1);
    pg(8'h80, 8'h01, 8'h00, 8'h00);
    rdc(uer_pkg::IDX_REV, 8'h00, 1'b1);
    rdc(uer_pkg::IDX_ID, 8'h00, 1'b1);
    wrt(uer_pkg::IDX_AFR, 8'hff, 1'b0);
    rdc(uer_pkg::IDX_AFR, 8'h02, 1'b0);
    rdc(uer_pkg::IDX_ASR, 8'h00, 1'b1);
    pg(8'h80, 8'h00, 8'h01, 8'h00);
    rdc(uer_pkg::IDX_REV, REV_CODE, 1'b0);
    rdc(uer_pkg::IDX_ID, 8'h00, 1'b1);
    pg(8'h3f, 8'h00, 8'h00, 8'h00);
    rdc(uer_pkg::IDX_REV, 8'h00, 1'b1);
    pg(8'hbf, 8'h00, 8'h00, 8'h10);
    rdc(uer_pkg::IDX_ASR, 8'h00, 1'b1);
    rdc(uer_pkg::IDX_SECOND_XOFF_CHARACTER, uer_pkg::RST_SECOND_XOFF_CHARACTER, 1'b0);
    d = 8'($urandom);
    wrt(uer_pkg::IDX_SECOND_XOFF_CHARACTER, d, 1'b0);
    acc(1'b1, uer_pkg::IDX_SECOND_XOFF_CHARACTER, ~d, 4'h0, 8'h00, 1'b0);
    rdc(uer_pkg::IDX_SECOND_XOFF_CHARACTER, d, 1'b0);
    `CHK(second_xoff_character, d)
    v = 7'($urandom_range(0, 64));
    t = 7'($urandom_range(0, 64));
    @(posedge sys_clk_i);
    rx_fill <= v;
    tx_fill <= t;
    rdc(uer_pkg::IDX_FC, {1'b0, v}, 1'b0);
    rdc(uer_pkg::IDX_FC, {1'b1, t}, 1'b0);
    rdc(uer_pkg::IDX_FC, {1'b0, v}, 1'b0);
    for (i = 0; i < 2; i++) begin
      v = (i == 0) ? 7'($urandom_range(0, 63)) : uer_pkg::TRG_MAX;
      wrt(uer_pkg::IDX_TRG, {1'b0, v}, 1'b0);
      wrt(uer_pkg::IDX_TRG, {1'b1, uer_pkg::TRG_MAX - v}, 1'b0);
      #1;
      `CHK(rxt, v)
      `CHK(txt, uer_pkg::TRG_MAX - v)
    end
    wrt(uer_pkg::IDX_TRG, 8'h41, 1'b0);
    wrt(uer_pkg::IDX_TRG, 8'hff, 1'b0);
    #1;
    `CHK(rxt, uer_pkg::TRG_MAX)
    `CHK(txt, 7'h00)
    for (i = 0; i < 16; i++) begin
      c = 4'(i);
      d = {2'b11, 2'($urandom), c};
      wrt(uer_pkg::IDX_FEATURE_CONTROL, d, 1'b0);
      rdc(uer_pkg::IDX_FEATURE_CONTROL, {2'b00, d[5:0]}, 1'b0);
      `CHK(tbl, d[5:4])
      `CHK(hyst, hyst_of(c))
    end
    pg(8'h80, 8'h00, 8'h00, 8'h10);
    d = 8'($urandom) | 8'h04;
    wrt(uer_pkg::IDX_ASR, d, 1'b0);
    rdc(uer_pkg::IDX_ASR, d, 1'b0);
    `CHK(advanced_special, d)
    do begin
      sc = 4'($urandom);
      np = 4'($urandom);
    end while (int'(sc) - int'(np) >= 15);
    wrt(uer_pkg::IDX_SNR, {sc, np}, 1'b0);
    rdc(uer_pkg::IDX_SNR, {sc, np}, 1'b0);
    `CHK(sample_clock_baud, {sc, np})
    wrt(uer_pkg::IDX_ASR, d & 8'hfb, 1'b0);
    rdc(uer_pkg::IDX_SNR, 8'h00, 1'b1);
    pg(8'hbf, 8'h00, 8'h00, 8'h00);
    t = 7'($urandom_range(52, 64));
    c = 4'($urandom_range(1, 15));
    h = hyst_of(c);
    wrt(uer_pkg::IDX_FEATURE_CONTROL, {4'h3, c}, 1'b0);
    wrt(uer_pkg::IDX_TRG, {1'b0, t}, 1'b0);
    @(posedge sys_clk_i);
    rts_en <= 1'b1;
    tbl_lvl <= t;
    fill(7'(t + h - 7'h01), 1'b1);
    fill(7'(t + h), 1'b0);
    fill(7'(t - h + 7'h01), 1'b0);
    fill(7'(t - h), 1'b1);
    wrt(uer_pkg::IDX_FEATURE_CONTROL, {4'h0, c}, 1'b0);
    fill(t - 7'h01, 1'b1);
    fill(t, 1'b0);
    fill(t - 7'h01, 1'b1);
    close_out();
  end
endmodule
